// file: src/cdt_debug_tap.sv
// How it works
// - probe loads select opcode with compliance high
// - instruction bits shift in lsb first
// - last instruction bit goes with mode high
// - selection is eleven ticks from idle
// - ten-bit command shift acts as instruction register
// - active command changes only at update-ir
// - bit zero chooses write or read
// - direction ignored for read-only and bypass targets
// - capture-dr loads word shifted out first
// - go runs the scan chain instruction
// - go without exit returns to debug
// - go with exit resumes normal run unless another debug request stands
// - go honoured only for scan chain, none
// - core leaves debug only after update-dr
// - pre-empted step sets debug error flag
// - bits three to nine select target register
// - exit bit leaves debug only with go
// - codes for scan chain and no-register bypass
// - inputs on rising edge, output on falling
`timescale 1ns/1ps
`include "cdt_regs.svh"
module cdt_debug_tap (
  cdt_link_if.dev_mp link, // test access port
  input wire logic i_core_clk, // core clock
  input wire logic i_rst_b, // core reset, active low
  input wire logic [31:0] i_reg_rdata, // contents of the register at o_reg_sel
  input wire logic i_exec_done, // core finished the single instruction
  input wire logic i_preempt, // exception took the step instead
  input wire logic i_other_dbg_req, // another source wants debug mode
  input wire logic i_debug_req, // request to enter debug mode
  input wire logic i_err_clr, // clears the debug error flag
  output logic [6:0] o_reg_sel, // register selected for read or write
  output logic [31:0] o_wr_data, // write data
  output logic o_wr_stb, // one-cycle write strobe
  output logic o_exec_req, // one-cycle request to run the scan chain instruction
  output logic o_exec_leave, // exit flag that goes with the request
  output logic o_debug_mode, // core is halted in debug mode
  output logic o_err_flag // debug_status_error_flag
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // selections that behave as a one-bit bypass
  function automatic logic is_bypass(input logic [6:0] sel);
    is_bypass = (sel == `CDT_SEL_NONE) || (sel == `CDT_SEL_ENBYP) || (sel == `CDT_SEL_BYP);
  endfunction : is_bypass

  // targets that cannot be written
  function automatic logic is_read_only(input logic [6:0] sel);
    is_read_only = (sel == `CDT_SEL_DID) || (sel == `CDT_SEL_PCFIFO);
  endfunction : is_read_only

  // standard tap transition on mode select
  function automatic cdt_pkg::cdt_tap_type tap_next(input cdt_pkg::cdt_tap_type s,
                                                   input logic tms);
    case (s)
      cdt_pkg::TAP_TLR: tap_next = tms ? cdt_pkg::TAP_TLR : cdt_pkg::TAP_RTI;
      cdt_pkg::TAP_RTI: tap_next = tms ? cdt_pkg::TAP_SDR : cdt_pkg::TAP_RTI;
      cdt_pkg::TAP_SDR: tap_next = tms ? cdt_pkg::TAP_SIR : cdt_pkg::TAP_CDR;
      cdt_pkg::TAP_CDR: tap_next = tms ? cdt_pkg::TAP_E1DR : cdt_pkg::TAP_SHDR;
      cdt_pkg::TAP_SHDR: tap_next = tms ? cdt_pkg::TAP_E1DR : cdt_pkg::TAP_SHDR;
      cdt_pkg::TAP_E1DR: tap_next = tms ? cdt_pkg::TAP_UDR : cdt_pkg::TAP_PDR;
      cdt_pkg::TAP_PDR: tap_next = tms ? cdt_pkg::TAP_E2DR : cdt_pkg::TAP_PDR;
      cdt_pkg::TAP_E2DR: tap_next = tms ? cdt_pkg::TAP_UDR : cdt_pkg::TAP_SHDR;
      cdt_pkg::TAP_UDR: tap_next = tms ? cdt_pkg::TAP_SDR : cdt_pkg::TAP_RTI;
      cdt_pkg::TAP_SIR: tap_next = tms ? cdt_pkg::TAP_TLR : cdt_pkg::TAP_CIR;
      cdt_pkg::TAP_CIR: tap_next = tms ? cdt_pkg::TAP_E1IR : cdt_pkg::TAP_SHIR;
      cdt_pkg::TAP_SHIR: tap_next = tms ? cdt_pkg::TAP_E1IR : cdt_pkg::TAP_SHIR;
      cdt_pkg::TAP_E1IR: tap_next = tms ? cdt_pkg::TAP_UIR : cdt_pkg::TAP_PIR;
      cdt_pkg::TAP_PIR: tap_next = tms ? cdt_pkg::TAP_E2IR : cdt_pkg::TAP_PIR;
      cdt_pkg::TAP_E2IR: tap_next = tms ? cdt_pkg::TAP_UIR : cdt_pkg::TAP_SHIR;
      cdt_pkg::TAP_UIR: tap_next = tms ? cdt_pkg::TAP_SDR : cdt_pkg::TAP_RTI;
      default: tap_next = cdt_pkg::TAP_TLR;
    endcase
  endfunction : tap_next

  ////////////////////////////////////////////////////////////////////////////
  // link clock domain

  cdt_pkg::cdt_link_st_type lq; // registered link state
  cdt_pkg::cdt_link_st_type ld; // next link state
  cdt_pkg::cdt_core_st_type cq; // registered core state
  cdt_pkg::cdt_core_st_type cd; // next core state
  logic [6:0] act_sel; // select field of the active command
  logic tdo_q; // output bit, launched on the falling edge

  assign act_sel = lq.cmd[`CDT_SEL_MSB:`CDT_SEL_LSB];

  // tap controller, command path and data path
  always_comb begin
    ld = lq;
    ld.tap = tap_next(lq.tap, link.tms);
    case (lq.tap)
      cdt_pkg::TAP_TLR: begin
        // test-logic-reset gives the tap back to the top controller
        ld.aux = 1'b0;
        ld.paused = 1'b0;
        ld.top_ir = `CDT_TOP_IR_RESET;
      end
      cdt_pkg::TAP_CIR: begin
        if (lq.aux) begin
          ld.cmd_sh = `CDT_CMD_CAPT;
        end else begin
          ld.ir_sh = `CDT_TOP_IR_CAPT;
        end
      end
      cdt_pkg::TAP_SHIR: begin
        // lsb leaves first, new bit enters at the top
        if (lq.aux) begin
          ld.cmd_sh = {link.tdi, lq.cmd_sh[9:1]};
        end else begin
          ld.ir_sh = {link.tdi, lq.ir_sh[4:1]};
        end
      end
      cdt_pkg::TAP_UIR: begin
        if (lq.aux) begin
          ld.cmd = lq.cmd_sh;
          ld.rq_tgl = ~lq.rq_tgl; // ask the core side for a fresh snapshot
        end else begin
          ld.top_ir = lq.ir_sh;
          if (lq.ir_sh == `CDT_SEL_OPCODE) begin
            ld.aux = 1'b1;
            ld.paused = 1'b0;
          end
        end
      end
      cdt_pkg::TAP_CDR: begin
        ld.byp = 1'b0;
        // snapshot is stable here: taken after update-ir, before this scan
        if (lq.aux && !is_bypass(act_sel)) begin
          ld.dr = cq.snap;
        end
      end
      cdt_pkg::TAP_SHDR: begin
        ld.dr = {link.tdi, lq.dr[31:1]};
        ld.byp = link.tdi;
      end
      cdt_pkg::TAP_PDR: begin
        ld.paused = lq.aux;
      end
      cdt_pkg::TAP_UDR: begin
        if (lq.aux) begin
          // direction only matters for writable, non-bypass targets
          if (!lq.cmd[`CDT_CMD_RW] && !is_read_only(act_sel) &&
              !is_bypass(act_sel)) begin
            ld.wr_data = lq.dr;
            ld.wr_sel = act_sel;
            ld.wr_tgl = ~lq.wr_tgl;
          end
          // go released only here, and only for scan chain or no register
          if (lq.cmd[`CDT_CMD_GO] &&
              (act_sel == `CDT_SEL_SCAN || act_sel == `CDT_SEL_NONE)) begin
            ld.go_tgl = ~lq.go_tgl;
          end
          if (lq.paused) begin
            ld.aux = 1'b0; // pause seen: top controller takes the tap back
          end
        end
      end
      default: begin
        ld.paused = lq.paused;
      end
    endcase
  end

  // link registers; compliance low holds the tap in reset
  always_ff @(posedge link.tck) begin
    if (!link.tap_compliance_enable) begin
      lq <= '{tap: cdt_pkg::TAP_TLR, ir_sh: `CDT_TOP_IR_RESET, top_ir: `CDT_TOP_IR_RESET,
              cmd_sh: `CDT_CMD_RESET, cmd: `CDT_CMD_RESET, default: '0};
    end else begin
      lq <= ld;
    end
  end

  // output bit changes on the falling edge only
  always_ff @(negedge link.tck) begin
    if (lq.tap == cdt_pkg::TAP_SHIR) begin
      tdo_q <= lq.aux ? lq.cmd_sh[0] : lq.ir_sh[0];
    end else if (lq.tap == cdt_pkg::TAP_SHDR) begin
      tdo_q <= (lq.aux && !is_bypass(act_sel)) ? lq.dr[0] : lq.byp;
    end else begin
      tdo_q <= 1'b0;
    end
  end

  assign link.tdo = tdo_q;

  ////////////////////////////////////////////////////////////////////////////
  // core clock domain

  logic wr_ev; // write toggle seen
  logic go_ev; // go toggle seen
  logic rq_ev; // snapshot toggle seen

  // toggles are compared on the second and third stages only
  assign wr_ev = cq.wr_s[1] ^ cq.wr_s[2];
  assign go_ev = cq.go_s[1] ^ cq.go_s[2];
  assign rq_ev = cq.rq_s[1] ^ cq.rq_s[2];

  // crossings, register access and run control
  always_comb begin
    cd = cq;
    cd.wr_s = {cq.wr_s[1:0], lq.wr_tgl};
    cd.go_s = {cq.go_s[1:0], lq.go_tgl};
    cd.rq_s = {cq.rq_s[1:0], lq.rq_tgl};
    cd.wr_stb = 1'b0;
    cd.exec_req = 1'b0;
    cd.rd_pend = 1'b0;
    if (rq_ev) begin
      // command is stable since update-ir
      cd.sel = lq.cmd[`CDT_SEL_MSB:`CDT_SEL_LSB];
      cd.rd_pend = 1'b1;
    end
    if (cq.rd_pend) begin
      cd.snap = i_reg_rdata;
    end
    if (wr_ev) begin
      cd.sel = lq.wr_sel;
      cd.wdata = lq.wr_data;
      cd.wr_stb = 1'b1;
    end
    case (cq.cst)
      cdt_pkg::CORE_RUN: begin
        if (i_debug_req) begin
          cd.cst = cdt_pkg::CORE_DBG;
        end
      end
      cdt_pkg::CORE_DBG: begin
        if (go_ev) begin
          cd.exec_req = 1'b1;
          cd.leave = lq.cmd[`CDT_CMD_EXIT];
          if (lq.cmd[`CDT_CMD_EXIT] && !i_other_dbg_req) begin
            cd.cst = cdt_pkg::CORE_RUN;
          end else begin
            cd.cst = cdt_pkg::CORE_STEP;
          end
        end
      end
      cdt_pkg::CORE_STEP: begin
        // return counts as a debug event; an exception may win
        if (i_preempt || i_exec_done) begin
          cd.cst = cdt_pkg::CORE_DBG;
        end
      end
      default: begin
        cd.cst = cdt_pkg::CORE_RUN;
      end
    endcase
    // error flag: a new set wins over a clear in the same cycle
    if (cq.cst == cdt_pkg::CORE_STEP && i_preempt) begin
      cd.err = 1'b1;
    end else if (i_err_clr) begin
      cd.err = 1'b0;
    end
  end

  // core registers
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      cq <= '{cst: cdt_pkg::CORE_RUN, default: '0};
    end else begin
      cq <= cd;
    end
  end

  assign o_reg_sel = cq.sel;
  assign o_wr_data = cq.wdata;
  assign o_wr_stb = cq.wr_stb;
  assign o_exec_req = cq.exec_req;
  assign o_exec_leave = cq.leave;
  assign o_debug_mode = (cq.cst != cdt_pkg::CORE_RUN);
  assign o_err_flag = cq.err;

endmodule : cdt_debug_tap

// file: src/cdt_regs.svh
`ifndef CDT_REGS_SVH
`define CDT_REGS_SVH
// top-level instruction register and the opcode that hands over the tap
`define CDT_TOP_IR_W 5
`define CDT_SEL_OPCODE 5'h11
`define CDT_TOP_IR_CAPT 5'h01
`define CDT_TOP_IR_RESET 5'h1F
// debug command layout
`define CDT_CMD_W 10
`define CDT_CMD_CAPT 10'h001
`define CDT_CMD_RESET 10'h000
`define CDT_CMD_RW 0
`define CDT_CMD_GO 1
`define CDT_CMD_EXIT 2
`define CDT_SEL_LSB 3
`define CDT_SEL_MSB 9
// select codes with behaviour of their own
`define CDT_SEL_SCAN 7'h10
`define CDT_SEL_NONE 7'h11
`define CDT_SEL_ENBYP 7'h7E
`define CDT_SEL_BYP 7'h7F
`define CDT_SEL_DID 7'h02
`define CDT_SEL_PCFIFO 7'h2D
// data path
`define CDT_DR_W 32
// probe timing: ticks to reach idle, trailing idle ticks
`define CDT_INIT_TICKS 6'h06
`define CDT_RESET_TICKS 6'h05
`define CDT_IR_PRE 6'h04
`define CDT_DR_PRE 6'h03
`define CDT_POST_TICKS 6'h04
`define CDT_TCK_HALF 4
`endif

// file: src/cdt_pkg.sv
package cdt_pkg;
  // tap controller states, one-hot
  typedef enum logic [15:0] {
    TAP_TLR = 16'h0001, TAP_RTI = 16'h0002, TAP_SDR = 16'h0004, TAP_CDR = 16'h0008,
    TAP_SHDR = 16'h0010, TAP_E1DR = 16'h0020, TAP_PDR = 16'h0040, TAP_E2DR = 16'h0080,
    TAP_UDR = 16'h0100, TAP_SIR = 16'h0200, TAP_CIR = 16'h0400, TAP_SHIR = 16'h0800,
    TAP_E1IR = 16'h1000, TAP_PIR = 16'h2000, TAP_E2IR = 16'h4000, TAP_UIR = 16'h8000
  } cdt_tap_type;
  // core run state as seen by the debug unit
  typedef enum logic [2:0] {
    CORE_RUN = 3'h1, CORE_DBG = 3'h2, CORE_STEP = 3'h4
  } cdt_core_type;
  // probe sequencer
  typedef enum logic [4:0] {
    PRB_INIT = 5'h01, PRB_IDLE = 5'h02, PRB_SEL = 5'h04, PRB_CMD = 5'h08, PRB_DATA = 5'h10
  } cdt_prb_type;
  // device state on the link clock
  typedef struct packed {
    cdt_tap_type tap;
    logic [4:0] ir_sh;
    logic [4:0] top_ir;
    logic aux;
    logic paused;
    logic [9:0] cmd_sh;
    logic [9:0] cmd;
    logic [31:0] dr;
    logic byp;
    logic [31:0] wr_data;
    logic [6:0] wr_sel;
    logic wr_tgl;
    logic go_tgl;
    logic rq_tgl;
  } cdt_link_st_type;
  // device state on the core clock
  typedef struct packed {
    logic [2:0] wr_s;
    logic [2:0] go_s;
    logic [2:0] rq_s;
    logic rd_pend;
    logic [31:0] snap;
    logic [6:0] sel;
    logic [31:0] wdata;
    logic wr_stb;
    cdt_core_type cst;
    logic exec_req;
    logic leave;
    logic err;
  } cdt_core_st_type;
  // probe state
  typedef struct packed {
    logic [7:0] div;
    logic tck;
    logic tms;
    logic tdi;
    logic comp_en;
    logic [1:0] tdo_s;
    cdt_prb_type st;
    logic [5:0] pos;
    logic [5:0] len;
    logic is_ir;
    logic [31:0] tx;
    logic [31:0] rx;
    logic selected;
    logic [9:0] cmd;
    logic [31:0] wdata;
    logic ready;
    logic rvalid;
    logic [31:0] rdata;
  } cdt_prb_st_type;
endpackage : cdt_pkg

// file: src/cdt_link_if.sv
`timescale 1ns/1ps
// test access port between probe and device
interface cdt_link_if;
  logic tck; // link clock, made by the probe
  logic tms; // mode select
  logic tdi; // data toward device
  logic tdo; // data toward probe
  logic tap_compliance_enable; // high lets the tap leave reset
  modport probe_mp (output tck, output tms, output tdi, output tap_compliance_enable,
    input tdo);
  modport dev_mp (input tck, input tms, input tdi, input tap_compliance_enable,
    output tdo);
endinterface : cdt_link_if

// file: src/cdt_probe.sv
`timescale 1ns/1ps
`include "cdt_regs.svh"
module cdt_probe #(
  parameter int TCK_HALF = `CDT_TCK_HALF // core cycles per half link clock
) (
  cdt_link_if.probe_mp link, // test access port
  input wire logic i_core_clk, // core clock
  input wire logic i_rst_b, // reset, active low
  input wire logic i_cmd_valid, // start one command and data scan
  input wire logic [9:0] i_cmd, // debug command to load
  input wire logic [31:0] i_wdata, // word shifted into the data register
  output logic o_cmd_ready, // idle, takes i_cmd_valid
  output logic [31:0] o_rdata, // word shifted out
  output logic o_rvalid, // one-cycle pulse, o_rdata valid
  output logic o_selected // core debug tap has been selected
);

  // divider must leave time for the output bit synchroniser
  if (TCK_HALF < 3 || TCK_HALF > 255) begin : g_chk
    $error("cdt_probe: TCK_HALF out of range");
  end

  cdt_pkg::cdt_prb_st_type q; // registered state
  cdt_pkg::cdt_prb_st_type d; // next state
  logic [5:0] pre; // ticks from idle to shift
  logic rise; // link clock goes high this edge
  logic fall; // link clock goes low this edge
  logic in_shift; // current tick is a shift tick

  // mode select for tick p of a scan of n bits
  function automatic logic tms_at(input logic [5:0] p, input logic ir, input logic [5:0] n);
    logic [5:0] pr;
    pr = ir ? `CDT_IR_PRE : `CDT_DR_PRE;
    if (p < pr) begin
      tms_at = ir ? (p < 6'h02) : (p < 6'h01);
    end else if (p < pr + n) begin
      tms_at = (p == pr + n - 6'h01);
    end else begin
      tms_at = (p == pr + n);
    end
  endfunction : tms_at

  assign pre = q.is_ir ? `CDT_IR_PRE : `CDT_DR_PRE;
  assign rise = (q.div == 8'(TCK_HALF - 1)) && !q.tck;
  assign fall = (q.div == 8'(TCK_HALF - 1)) && q.tck;
  assign in_shift = (q.pos >= pre) && (q.pos < pre + q.len);

  ////////////////////////////////////////////////////////////////////////////
  // sequencer

  // divider, scan engine and command flow
  always_comb begin
    d = q;
    d.rvalid = 1'b0;
    // compliance stays low over the first rising link edge so the tap resets
    d.comp_en = (q.st != cdt_pkg::PRB_INIT) || (q.pos != 6'h00);
    d.tdo_s = {q.tdo_s[0], link.tdo};
    d.div = (q.div == 8'(TCK_HALF - 1)) ? 8'h00 : q.div + 8'h01;
    if (q.div == 8'(TCK_HALF - 1)) begin
      d.tck = ~q.tck;
    end
    // sample output bit at the rising edge of a shift tick
    if (rise && q.st != cdt_pkg::PRB_INIT && q.st != cdt_pkg::PRB_IDLE && in_shift) begin
      d.rx = {q.tdo_s[1], q.rx[31:1]};
    end
    case (q.st)
      cdt_pkg::PRB_INIT: begin
        // five ticks high then one low: idle from any state
        if (fall) begin
          d.pos = q.pos + 6'h01;
          d.tms = (q.pos + 6'h01) < `CDT_RESET_TICKS;
          if (q.pos + 6'h01 == `CDT_INIT_TICKS) begin
            d.st = cdt_pkg::PRB_IDLE;
            d.tms = 1'b0;
            d.ready = 1'b1;
          end
        end
      end
      cdt_pkg::PRB_IDLE: begin
        if (i_cmd_valid && q.ready) begin
          d.ready = 1'b0;
          d.cmd = i_cmd;
          d.wdata = i_wdata;
          // one before the first tick: mode and data move only at the next fall
          d.pos = '1;
          d.is_ir = 1'b1;
          if (q.selected) begin
            d.st = cdt_pkg::PRB_CMD;
            d.len = 6'(`CDT_CMD_W);
            d.tx = {22'h000000, i_cmd};
          end else begin
            d.st = cdt_pkg::PRB_SEL;
            d.len = 6'(`CDT_TOP_IR_W);
            d.tx = {27'h0000000, `CDT_SEL_OPCODE};
          end
        end
      end
      default: begin
        // scan in progress: advance one tick per falling edge
        if (fall) begin
          d.pos = q.pos + 6'h01;
          if (in_shift) begin
            d.tx = {1'b0, q.tx[31:1]};
          end
          d.tdi = d.tx[0];
          d.tms = tms_at(d.pos, q.is_ir, q.len);
          if (q.pos == pre + q.len + `CDT_POST_TICKS - 6'h01) begin
            d.pos = 6'h00;
            d.tms = 1'b1;
            case (q.st)
              cdt_pkg::PRB_SEL: begin
                d.selected = 1'b1;
                d.st = cdt_pkg::PRB_CMD;
                d.len = 6'(`CDT_CMD_W);
                d.tx = {22'h000000, q.cmd};
              end
              cdt_pkg::PRB_CMD: begin
                d.st = cdt_pkg::PRB_DATA;
                d.is_ir = 1'b0;
                d.len = (q.cmd[`CDT_SEL_MSB:`CDT_SEL_LSB] == `CDT_SEL_NONE ||
                         q.cmd[`CDT_SEL_MSB:`CDT_SEL_LSB] == `CDT_SEL_ENBYP ||
                         q.cmd[`CDT_SEL_MSB:`CDT_SEL_LSB] == `CDT_SEL_BYP) ?
                        6'h01 : 6'(`CDT_DR_W);
                d.tx = q.wdata;
              end
              default: begin
                d.st = cdt_pkg::PRB_IDLE;
                d.tms = 1'b0;
                d.ready = 1'b1;
                d.rvalid = 1'b1;
                d.rdata = q.rx >> (6'(`CDT_DR_W) - q.len);
              end
            endcase
            d.tdi = d.tx[0];
          end
        end
      end
    endcase
  end

  // registers
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      q <= '{st: cdt_pkg::PRB_INIT, tms: 1'b1, default: '0};
    end else begin
      q <= d;
    end
  end

  assign link.tck = q.tck;
  assign link.tms = q.tms;
  assign link.tdi = q.tdi;
  assign link.tap_compliance_enable = q.comp_en;
  assign o_cmd_ready = q.ready;
  assign o_rdata = q.rdata;
  assign o_rvalid = q.rvalid;
  assign o_selected = q.selected;

endmodule : cdt_probe

// file: testbench/cdt_link_props.sv
`timescale 1ns/1ps
// watches the link between probe and device
module cdt_link_props (
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  input wire logic tdo,
  input wire logic tap_compliance_enable
);
  // next tap state for tms high and for tms low, one nibble per state code
  localparam logic [63:0] NXT_HI = 64'h2FEF_CC02_8785_5920;
  localparam logic [63:0] NXT_LO = 64'h1BDD_BBA1_4664_4311;
  logic [3:0] st_q; // mirrored tap state, 4 shift-dr, A capture-ir, B shift-ir, F update-ir
  logic [5:0] cnt_q; // shift ticks already taken
  logic [1:0] age_q; // ticks since enable, saturating
  logic sel_q; // an update-ir has been seen
  logic tdo_q; // tdo at the last rising edge
  logic tms_q; // tms at the last rising edge
  logic tdi_q; // tdi at the last rising edge
  //////////////////////////////////////////////////////////////////////////////
  // mirror of the tap controller, cleared while enable is low
  always_ff @(posedge tck or negedge tap_compliance_enable) begin
    if (!tap_compliance_enable) begin
      st_q <= 4'h0;
      cnt_q <= 6'h00;
      age_q <= 2'h0;
      sel_q <= 1'b0;
    end else begin
      st_q <= tms ? NXT_HI[{st_q, 2'b00} +: 4] : NXT_LO[{st_q, 2'b00} +: 4];
      cnt_q <= (st_q == 4'h4 || st_q == 4'hB) ? cnt_q + 6'h01 : 6'h00;
      age_q <= (age_q == 2'h3) ? age_q : age_q + 2'h1;
      sel_q <= sel_q | (st_q == 4'hF);
      tdo_q <= tdo;
      tms_q <= tms;
      tdi_q <= tdi;
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  // first selection walk from idle, opcode lsb first
  a_select_walk: assert property (@(posedge tck) disable iff (!tap_compliance_enable)
    (st_q == 4'h1 && tms && !sel_q) |-> ##1 tms ##1 !tms ##1 !tms ##1 (!tms && tdi)
    ##1 (!tms && !tdi)[*3] ##1 (tms && tdi) ##1 tms ##1 !tms) else $error("bad select walk");
  // five instruction bits before selection, ten after
  a_ir_length: assert property (@(posedge tck) disable iff (!tap_compliance_enable)
    (st_q == 4'hB && tms) |-> cnt_q == (sel_q ? 6'h09 : 6'h04)) else $error("bad ir length");
  // data scans are a full word or a single bypass bit
  a_dr_length: assert property (@(posedge tck) disable iff (!tap_compliance_enable)
    (st_q == 4'h4 && tms) |-> (cnt_q == 6'h1F || cnt_q == 6'h00)) else $error("bad dr length");
  // captured pattern leaves bit zero first
  a_ir_capture: assert property (@(posedge tck) disable iff (!tap_compliance_enable)
    (st_q == 4'hA && !tms && age_q == 2'h3) |-> ##1 tdo ##1 !tdo) else $error("bad capture");
  // idle ticks follow every update-ir
  a_update_idle: assert property (@(posedge tck) disable iff (!tap_compliance_enable)
    (st_q == 4'hF) |-> !tms[*3]) else $error("no idle after update");
  // output is quiet outside shift states
  a_tdo_quiet: assert property (@(posedge tck) disable iff (!tap_compliance_enable)
    (age_q == 2'h3 && st_q != 4'h4 && st_q != 4'hB) |-> !tdo) else $error("tdo not quiet");
  // output holds while the clock is high
  a_tdo_held: assert property (@(negedge tck) disable iff (!tap_compliance_enable)
    (age_q >= 2'h2) |-> tdo == tdo_q) else $error("tdo moved on rising edge");
  // probe moves mode and data only on falling edge
  a_probe_held: assert property (@(negedge tck) disable iff (!tap_compliance_enable)
    (age_q != 2'h0) |-> (tms == tms_q && tdi == tdi_q)) else $error("probe moved early");
endmodule : cdt_link_props

// file: testbench/test_core_debug_tap_command.sv
`timescale 1ns/1ps
`define CDT_CHK(got, exp) \
  begin \
    comparisons++; \
    if ((got) !== (exp)) begin \
      failures++; \
      $display("ERROR %0t got %0h expected %0h", $time, (got), (exp)); \
    end \
  end
// probe and device face each other; the bench works both user sides
module test_core_debug_tap_command;
  logic core_clk; // core clock
  logic rst_b; // reset, active low
  logic cmd_valid, selected, cmd_ready, rvalid; // probe handshake
  logic [9:0] cmd; // command to scan
  logic [31:0] wdata, rdata, reg_rdata, wr_data, wr_dat; // data words
  logic exec_done, preempt, other_req, debug_req, err_clr; // core side inputs
  logic [6:0] reg_sel, wr_sel; // selects
  logic wr_stb, exec_req, exec_leave, debug_mode, err_flag, ex_lv; // core side outputs
  int failures = 0, comparisons = 0, cycles = 0, wr_cnt = 0, ex_cnt = 0; // tallies
  //////////////////////////////////////////////////////////////////////////////
  cdt_link_if u_cdt_link_if ();
  cdt_probe u_cdt_probe (.link(u_cdt_link_if.probe_mp), .i_core_clk(core_clk),
    .i_rst_b(rst_b), .i_cmd_valid(cmd_valid), .i_cmd(cmd), .i_wdata(wdata),
    .o_cmd_ready(cmd_ready), .o_rdata(rdata), .o_rvalid(rvalid), .o_selected(selected));
  cdt_debug_tap u_cdt_debug_tap (.link(u_cdt_link_if.dev_mp), .i_core_clk(core_clk),
    .i_rst_b(rst_b), .i_reg_rdata(reg_rdata), .i_exec_done(exec_done), .i_preempt(preempt),
    .i_other_dbg_req(other_req), .i_debug_req(debug_req), .i_err_clr(err_clr),
    .o_reg_sel(reg_sel), .o_wr_data(wr_data), .o_wr_stb(wr_stb), .o_exec_req(exec_req),
    .o_exec_leave(exec_leave), .o_debug_mode(debug_mode), .o_err_flag(err_flag));
  cdt_link_props u_cdt_link_props (.tck(u_cdt_link_if.tck), .tms(u_cdt_link_if.tms),
    .tdi(u_cdt_link_if.tdi), .tdo(u_cdt_link_if.tdo),
    .tap_compliance_enable(u_cdt_link_if.tap_compliance_enable));
  //////////////////////////////////////////////////////////////////////////////
  // modelled core register file, word tells its own select
  function automatic logic [31:0] rv(input logic [6:0] s);
    rv = {16'hC0DE, 9'h000, s};
  endfunction : rv
  assign reg_rdata = rv(reg_sel);
  // clock, 25 ns period
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  // tallies device strobes and cuts a hang short
  always @(negedge core_clk) begin
    cycles++;
    if (wr_stb) begin
      wr_cnt++;
      wr_sel = reg_sel;
      wr_dat = wr_data;
    end
    if (exec_req) begin
      ex_cnt++;
      ex_lv = exec_leave;
    end
    if (cycles == 30000) begin
      failures++;
      results();
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  // counts, verdict, end of run
  task automatic results();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : results
  // one command and data scan through the probe, ends at a falling edge
  task automatic scan(input logic [9:0] c, input logic [31:0] d);
    while (!cmd_ready) @(negedge core_clk);
    cmd = c;
    wdata = d;
    cmd_valid = 1'b1;
    @(negedge core_clk);
    cmd_valid = 1'b0;
    while (!rvalid) @(negedge core_clk);
    repeat (4) @(negedge core_clk);
  endtask : scan
  // one-cycle pulse on a core side input
  task automatic pulse(ref logic s);
    s = 1'b1;
    @(negedge core_clk);
    s = 1'b0;
    repeat (3) @(negedge core_clk);
  endtask : pulse
  // halt the core, then read a register through a fresh selection
  task automatic t_read();
    pulse(debug_req);
    scan({7'h12, 3'b001}, 32'hFFFF_FFFF);
    `CDT_CHK(selected, 1'b1)
    `CDT_CHK(rdata, rv(7'h12))
    `CDT_CHK(wr_cnt, 0)
  endtask : t_read
  // write one register, old contents come back out
  task automatic t_write();
    scan({7'h31, 3'b000}, 32'h5A5A_F00D);
    `CDT_CHK(wr_cnt, 1)
    `CDT_CHK(wr_sel, 7'h31)
    `CDT_CHK(wr_dat, 32'h5A5A_F00D)
    `CDT_CHK(rdata, rv(7'h31))
  endtask : t_write
  // writes to read-only and bypass targets are dropped
  task automatic t_refuse();
    logic [6:0] sels [5] = '{7'h02, 7'h2D, 7'h11, 7'h7E, 7'h7F};
    foreach (sels[i]) begin
      scan({sels[i], 3'b000}, 32'h1234_5678);
      `CDT_CHK(wr_cnt, 1)
    end
    scan({7'h02, 3'b001}, 32'h0);
    `CDT_CHK(rdata, rv(7'h02))
  endtask : t_refuse
  // go on a wrong target, exit alone, then single steps
  task automatic t_step();
    scan({7'h31, 3'b010}, 32'h0);
    `CDT_CHK(ex_cnt, 0)
    scan({7'h10, 3'b101}, 32'h0);
    `CDT_CHK(ex_cnt, 0)
    `CDT_CHK(debug_mode, 1'b1)
    scan({7'h10, 3'b011}, 32'h0);
    `CDT_CHK(ex_cnt, 1)
    `CDT_CHK(ex_lv, 1'b0)
    pulse(exec_done);
    `CDT_CHK(debug_mode, 1'b1)
    scan({7'h11, 3'b011}, 32'h0);
    `CDT_CHK(ex_cnt, 2)
    pulse(preempt);
    `CDT_CHK(err_flag, 1'b1)
    `CDT_CHK(debug_mode, 1'b1)
    pulse(err_clr);
    `CDT_CHK(err_flag, 1'b0)
  endtask : t_step
  // go with exit stays halted while another request stands, else runs
  task automatic t_exit();
    other_req = 1'b1;
    scan({7'h10, 3'b111}, 32'h0);
    `CDT_CHK(ex_lv, 1'b1)
    pulse(exec_done);
    `CDT_CHK(debug_mode, 1'b1)
    other_req = 1'b0;
    scan({7'h11, 3'b111}, 32'h0);
    `CDT_CHK(ex_cnt, 4)
    `CDT_CHK(debug_mode, 1'b0)
  endtask : t_exit
  //////////////////////////////////////////////////////////////////////////////
  // reset for 20 cycles, then the scenarios
  initial begin
    rst_b = 1'b0;
    cmd_valid = 1'b0;
    cmd = 10'h000;
    wdata = 32'h0000_0000;
    {exec_done, preempt, other_req, debug_req, err_clr} = 5'h00;
    repeat (20) @(negedge core_clk);
    rst_b = 1'b1;
    @(negedge core_clk);
    t_read();
    t_write();
    t_refuse();
    t_step();
    t_exit();
    results();
  end
endmodule : test_core_debug_tap_command
